/* File: design/system_config_misc_control.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - reset clears configuration register
// - bit 4 off blocks modem interrupt
// - bit 3 enables power-fail error interrupt
// - bit 1 routes ring to level 15
// - bit 2 picks density output source
// - alternate-mode interrupts off when bit 0 clear
// - diagnostic byte survives reset
// - aux1 reset clears outputs, unused read zero
// - aux1 bit 5 reads density sense pin
// - aux1 bit 3 drives link test pin
// - aux1 bit 2 drives monitor/mouse select
// - aux1 bit 1 write fires 4-clock pulse
// - aux1 bit 0 drives system LED
// - reset clears aux2 register
// - aux2 spare bits stored, no effect
// - power-fail status set, cleared by write/disable
// - battery or power-good low sets status
// - aux2 bit 0 drives power-off pin
// - modem reset clears low bits, upper zero
// - modem bit 2 mirrors ring pin
// - edge select 0 interrupts on falling edge
// - modem pending bit raises level 5
module system_config_misc_control (
    input wire logic I_CORE_CLK,               // system clock
    input wire logic I_RST,                    // async reset, high
    input wire logic [35:0] I_ADDR,            // register address
    input wire logic [7:0] I_WDATA,            // write data
    input wire logic I_WR,                     // write strobe
    input wire logic I_RD,                     // read strobe
    output logic [7:0] O_RDATA,                // read data
    input wire logic I_POWER_FAIL_N,           // power fail, low active
    input wire logic I_BATTERY_STATUS,         // battery ok, 0 = bad
    input wire logic I_POWER_GOOD,             // supply ok, 0 = bad
    input wire logic I_RING_INPUT_PIN,         // ring / msi pin
    input wire logic I_FLOPPY_DENSITY_SENSE_PIN, // density sense
    input wire logic I_FLOPPY_MOTOR_EN2,       // floppy motor enable 2
    input wire logic I_DENSITY_DEFAULT,        // default density source
    input wire logic I_ALT_MODE_IRQ,           // alternate-mode irq source
    output logic O_FLOPPY_DENSITY_SELECT,      // density select out
    output logic O_TERMINAL_COUNT_PULSE,       // floppy terminal count
    output logic O_SYSTEM_LED,                 // front panel led
    output logic O_LINK_TEST_EN,               // transceiver link test
    output logic O_MONITOR_MOUSE_SELECT,       // monitor/mouse mux
    output logic O_POWER_OFF,                  // power supply off
    output logic O_ALT_MODE_SEL,               // muxed pin function
    output logic O_ALT_MODE_IRQ,               // alternate-mode irq out
    output logic O_MODULE_ERROR_IRQ,           // level 15 interrupt
    output logic O_RING_INDICATE_IRQ           // level 5 interrupt
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [4:0] config_reg;
    logic [7:0] diag;
    logic [3:0] aux1;
    logic [7:0] aux2;
    logic [1:0] modem;
    logic [2:0] tc_count;
    logic ring_prev;
    logic wr_cfg, wr_aux1, wr_aux2, wr_diag, wr_modem;
    logic ring_edge, pfail_event, next_pfail;

    function automatic logic hit(input logic [35:0] a,
                                 input logic [35:0] r);
        hit = (a == r);
    endfunction

    assign wr_cfg = I_WR && hit(I_ADDR, sysctl_pkg::ADDR_CONFIG);
    assign wr_aux1 = I_WR && hit(I_ADDR, sysctl_pkg::ADDR_AUX1);
    assign wr_aux2 = I_WR && hit(I_ADDR, sysctl_pkg::ADDR_AUX2);
    assign wr_diag = I_WR && hit(I_ADDR, sysctl_pkg::ADDR_DIAG);
    assign wr_modem = I_WR && hit(I_ADDR, sysctl_pkg::ADDR_MODEM);

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            config_reg <= sysctl_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            config_reg <= I_WDATA[4:0];
        end
    end

    // diagnostic byte has no reset
    always_ff @(posedge I_CORE_CLK) begin
        if (wr_diag) begin
            diag <= I_WDATA;
        end
    end

    // ------------------------------------------------------------
    // auxiliary 1
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            aux1 <= sysctl_pkg::AUX1_RESET;
        end else if (wr_aux1) begin
            aux1 <= {I_WDATA[3:2], 1'b0, I_WDATA[0]};
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            tc_count <= 3'h0;
        end else if (wr_aux1 && I_WDATA[sysctl_pkg::AUX1_TERM_CNT]) begin
            tc_count <= sysctl_pkg::TC_PULSE_LEN;
        end else if (tc_count != 3'h0) begin
            tc_count <= tc_count - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // auxiliary 2 and power fail
    // ------------------------------------------------------------
    assign pfail_event = config_reg[sysctl_pkg::CFG_PFAIL_EN] &&
        !I_POWER_FAIL_N;
    always_comb begin
        next_pfail = aux2[sysctl_pkg::AUX2_PFAIL];
        if (wr_aux2 && I_WDATA[sysctl_pkg::AUX2_PFAIL_CLR]) begin
            next_pfail = 1'b0;
        end
        if (!config_reg[sysctl_pkg::CFG_PFAIL_EN]) begin
            next_pfail = 1'b0;
        end
        if (pfail_event || !I_BATTERY_STATUS || !I_POWER_GOOD) begin
            next_pfail = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            aux2 <= sysctl_pkg::AUX2_RESET;
        end else begin
            if (wr_aux2) begin
                aux2[7:6] <= I_WDATA[7:6];
                aux2[4:2] <= I_WDATA[4:2];
                aux2[sysctl_pkg::AUX2_POWER_OFF] <=
                    I_WDATA[sysctl_pkg::AUX2_POWER_OFF];
            end
            aux2[sysctl_pkg::AUX2_PFAIL] <= next_pfail;
            aux2[sysctl_pkg::AUX2_PFAIL_CLR] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // modem ring
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ring_prev <= 1'b1;
        end else begin
            ring_prev <= I_RING_INPUT_PIN;
        end
    end

    // falling edge at select 0, rising at select 1
    assign ring_edge = modem[sysctl_pkg::MODEM_EDGE_SEL] ?
        (!ring_prev && I_RING_INPUT_PIN) :
        (ring_prev && !I_RING_INPUT_PIN);

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            modem <= sysctl_pkg::MODEM_RESET;
        end else begin
            if (wr_modem) begin
                modem[sysctl_pkg::MODEM_EDGE_SEL] <=
                    I_WDATA[sysctl_pkg::MODEM_EDGE_SEL];
            end
            if (config_reg[sysctl_pkg::CFG_RING_IRQ_EN] &&
                !config_reg[sysctl_pkg::CFG_RING_SEL] && ring_edge) begin
                modem[sysctl_pkg::MODEM_PENDING] <= 1'b1;
            end else if (wr_modem &&
                         !I_WDATA[sysctl_pkg::MODEM_PENDING]) begin
                modem[sysctl_pkg::MODEM_PENDING] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else if (!I_RD) begin
            O_RDATA <= 8'h00;
        end else if (hit(I_ADDR, sysctl_pkg::ADDR_CONFIG)) begin
            O_RDATA <= {3'h0, config_reg};
        end else if (hit(I_ADDR, sysctl_pkg::ADDR_AUX1)) begin
            O_RDATA <= {2'h0, I_FLOPPY_DENSITY_SENSE_PIN, 1'b0,
                        aux1[3:2], 1'b0, aux1[0]};
        end else if (hit(I_ADDR, sysctl_pkg::ADDR_AUX2)) begin
            O_RDATA <= aux2;
        end else if (hit(I_ADDR, sysctl_pkg::ADDR_DIAG)) begin
            O_RDATA <= diag;
        end else if (hit(I_ADDR, sysctl_pkg::ADDR_MODEM)) begin
            O_RDATA <= {5'h00, I_RING_INPUT_PIN, modem};
        end else begin
            O_RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // pins and interrupts
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_FLOPPY_DENSITY_SELECT <= 1'b0;
            O_ALT_MODE_IRQ <= 1'b0;
            O_MODULE_ERROR_IRQ <= 1'b0;
            O_RING_INDICATE_IRQ <= 1'b0;
        end else begin
            O_FLOPPY_DENSITY_SELECT <= config_reg[sysctl_pkg::CFG_DENS_SRC]
                ? I_FLOPPY_MOTOR_EN2 : I_DENSITY_DEFAULT;
            O_ALT_MODE_IRQ <= config_reg[sysctl_pkg::CFG_ALT_MODE] &&
                I_ALT_MODE_IRQ;
            O_MODULE_ERROR_IRQ <= next_pfail ||
                (config_reg[sysctl_pkg::CFG_RING_IRQ_EN] &&
                 config_reg[sysctl_pkg::CFG_RING_SEL] &&
                 !I_RING_INPUT_PIN);
            O_RING_INDICATE_IRQ <= config_reg[sysctl_pkg::CFG_RING_IRQ_EN]
                && !config_reg[sysctl_pkg::CFG_RING_SEL]
                && modem[sysctl_pkg::MODEM_PENDING];
        end
    end

    assign O_TERMINAL_COUNT_PULSE = (tc_count != 3'h0);
    assign O_SYSTEM_LED = aux1[sysctl_pkg::AUX1_LED];
    assign O_LINK_TEST_EN = aux1[sysctl_pkg::AUX1_LINK_TEST];
    assign O_MONITOR_MOUSE_SELECT = aux1[sysctl_pkg::AUX1_MON_MSE];
    assign O_POWER_OFF = aux2[sysctl_pkg::AUX2_POWER_OFF];
    assign O_ALT_MODE_SEL = config_reg[sysctl_pkg::CFG_ALT_MODE];
endmodule

/* File: design/sysctl_pkg.sv */
package sysctl_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [35:0] ADDR_CONFIG = 36'h070180000;
    localparam logic [35:0] ADDR_AUX1 = 36'h007190000;
    localparam logic [35:0] ADDR_AUX2 = 36'h719100000;
    localparam logic [35:0] ADDR_DIAG = 36'h070180010;
    localparam logic [35:0] ADDR_MODEM = 36'h070180020;
    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    localparam int CFG_RING_IRQ_EN = 4;
    localparam int CFG_PFAIL_EN = 3;
    localparam int CFG_DENS_SRC = 2;
    localparam int CFG_RING_SEL = 1;
    localparam int CFG_ALT_MODE = 0;
    localparam logic [4:0] CFG_RESET = 5'h00;
    // ------------------------------------------------------------
    // auxiliary 1 fields
    // ------------------------------------------------------------
    localparam int AUX1_DENS_SENSE = 5;
    localparam int AUX1_LINK_TEST = 3;
    localparam int AUX1_MON_MSE = 2;
    localparam int AUX1_TERM_CNT = 1;
    localparam int AUX1_LED = 0;
    localparam logic [3:0] AUX1_RESET = 4'h0;
    // ------------------------------------------------------------
    // auxiliary 2 fields
    // ------------------------------------------------------------
    localparam int AUX2_PFAIL = 5;
    localparam int AUX2_PFAIL_CLR = 1;
    localparam int AUX2_POWER_OFF = 0;
    localparam logic [7:0] AUX2_RESET = 8'h00;
    localparam logic [7:0] AUX2_SPARE_MASK = 8'hDC;
    // ------------------------------------------------------------
    // modem fields
    // ------------------------------------------------------------
    localparam int MODEM_RING_LEVEL = 2;
    localparam int MODEM_EDGE_SEL = 1;
    localparam int MODEM_PENDING = 0;
    localparam logic [1:0] MODEM_RESET = 2'h0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TC_PULSE_CLKS = 4;
    localparam logic [2:0] TC_PULSE_LEN = 3'(TC_PULSE_CLKS);
endpackage

/* File: test/sysctl_assertions.sv */
`timescale 1ns/1ps
// --------------------
// port checks
// --------------------
module sysctl_checker (
    input wire logic I_CORE_CLK, // clock
    input wire logic I_RST, // reset
    input wire logic [35:0] I_ADDR, // address
    input wire logic [7:0] I_WDATA, // wdata
    input wire logic I_WR, // write
    input wire logic I_RD, // read
    input wire logic [7:0] O_RDATA, // rdata
    input wire logic I_BATTERY_STATUS, // battery
    input wire logic I_POWER_GOOD, // supply
    input wire logic I_RING_INPUT_PIN, // ring
    input wire logic I_FLOPPY_DENSITY_SENSE_PIN, // sense
    input wire logic I_ALT_MODE_IRQ, // alt in
    input wire logic O_TERMINAL_COUNT_PULSE, // tc
    input wire logic O_SYSTEM_LED, // led
    input wire logic O_LINK_TEST_EN, // link
    input wire logic O_MONITOR_MOUSE_SELECT, // mux
    input wire logic O_POWER_OFF, // off
    input wire logic O_ALT_MODE_SEL, // alt sel
    input wire logic O_ALT_MODE_IRQ, // alt out
    input wire logic O_MODULE_ERROR_IRQ, // level 15
    input wire logic O_RING_INDICATE_IRQ // level 5
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    wire wr_aux1 = I_WR && (I_ADDR == sysctl_pkg::ADDR_AUX1);
    wire wr_aux2 = I_WR && (I_ADDR == sysctl_pkg::ADDR_AUX2);
    wire wr_cfg = I_WR && (I_ADDR == sysctl_pkg::ADDR_CONFIG);
    wire rd_aux1 = I_RD && (I_ADDR == sysctl_pkg::ADDR_AUX1);
    wire rd_modem = I_RD && (I_ADDR == sysctl_pkg::ADDR_MODEM);
    a_tc_pulse_width: assert property (wr_aux1 && I_WDATA[1] |=>
        O_TERMINAL_COUNT_PULSE [*4] ##1 !O_TERMINAL_COUNT_PULSE)
        else $error("tc pulse width wrong");
    a_aux1_pin_drive: assert property (wr_aux1 |=>
        O_SYSTEM_LED == $past(I_WDATA[0]) &&
        O_MONITOR_MOUSE_SELECT == $past(I_WDATA[2]) &&
        O_LINK_TEST_EN == $past(I_WDATA[3])) else $error("aux1 pins wrong");
    a_aux1_read_bits: assert property (rd_aux1 |=>
        O_RDATA[7:6] == 2'h0 && !O_RDATA[4] && !O_RDATA[1] &&
        O_RDATA[5] == $past(I_FLOPPY_DENSITY_SENSE_PIN))
        else $error("aux1 read wrong");
    a_modem_read_bits: assert property (rd_modem |=>
        O_RDATA[7:3] == 5'h00 && O_RDATA[2] == $past(I_RING_INPUT_PIN))
        else $error("modem read wrong");
    a_supply_low_err: assert property (
        !I_BATTERY_STATUS || !I_POWER_GOOD |=> O_MODULE_ERROR_IRQ)
        else $error("supply fault irq missing");
    a_power_off_pin: assert property (wr_aux2 |=>
        O_POWER_OFF == $past(I_WDATA[0])) else $error("power off wrong");
    a_alt_sel_drive: assert property (wr_cfg |=>
        O_ALT_MODE_SEL == $past(I_WDATA[0])) else $error("alt sel wrong");
    a_alt_irq_gate: assert property (1'b1 |=>
        O_ALT_MODE_IRQ == $past(O_ALT_MODE_SEL && I_ALT_MODE_IRQ))
        else $error("alt irq gate wrong");
    c_tc_fire: cover property (wr_aux1 && I_WDATA[1]);
    c_ring_irq: cover property (O_RING_INDICATE_IRQ);
    c_error_irq: cover property (O_MODULE_ERROR_IRQ);
endmodule
bind system_config_misc_control sysctl_checker sysctl_checker_inst (.*);

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam logic [35:0] C = sysctl_pkg::ADDR_CONFIG;
    localparam logic [35:0] A1 = sysctl_pkg::ADDR_AUX1;
    localparam logic [35:0] A2 = sysctl_pkg::ADDR_AUX2;
    localparam logic [35:0] D = sysctl_pkg::ADDR_DIAG;
    localparam logic [35:0] M = sysctl_pkg::ADDR_MODEM;
    logic clk = 0, rst = 1, wr = 0, rd = 0, pf_n = 1, bat = 1, ring = 1;
    logic sense = 1, mot2 = 0, alt_in = 0, dens, tc, led, link, mon, poff;
    logic alt_irq, err_irq, ring_irq;
    logic pgood = 1, dflt = 0;
    logic [35:0] addr = '0;
    logic [7:0] wdata = '0, rdata;
    int error_cnt = 0, checks_done = 0;
    system_config_misc_control system_config_misc_control_inst (
        .I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_POWER_FAIL_N(pf_n),
        .I_BATTERY_STATUS(bat), .I_POWER_GOOD(pgood), .I_RING_INPUT_PIN(ring),
        .I_FLOPPY_DENSITY_SENSE_PIN(sense), .I_FLOPPY_MOTOR_EN2(mot2),
        .I_DENSITY_DEFAULT(dflt), .I_ALT_MODE_IRQ(alt_in),
        .O_FLOPPY_DENSITY_SELECT(dens), .O_TERMINAL_COUNT_PULSE(tc),
        .O_SYSTEM_LED(led), .O_LINK_TEST_EN(link),
        .O_MONITOR_MOUSE_SELECT(mon), .O_POWER_OFF(poff), .O_ALT_MODE_SEL(),
        .O_ALT_MODE_IRQ(alt_irq), .O_MODULE_ERROR_IRQ(err_irq),
        .O_RING_INDICATE_IRQ(ring_irq));
    // --------------------
    // bus and check tasks
    // --------------------
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(logic [35:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(logic [35:0] a, logic [7:0] e, string n);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        chk(n, rdata, e);
    endtask
    task automatic idle(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_aux1();
        int n = 0;
        wr_reg(A1, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            #1;
            n += int'(tc);
            @(posedge clk);
        end
        chk("tc width", 8'(n), 8'h04);
        chk("aux1 pins", {5'h00, link, mon, led}, 8'h07);
        rd_reg(A1, 8'h2D, "aux1 readback");
        @(posedge clk) sense <= 0;
        wr_reg(A1, 8'h01);
        idle(0);
        chk("led only", {5'h00, link, mon, led}, 8'h01);
        rd_reg(A1, 8'h01, "aux1 sense low");
        @(posedge clk) sense <= 1;
        $display("aux1 test done");
    endtask
    task automatic t_aux2();
        wr_reg(A2, 8'hDF);
        rd_reg(A2, 8'hDD, "aux2 spare");
        chk("power off", 8'(poff), 8'h01);
        wr_reg(A2, 8'h00);
        $display("aux2 test done");
    endtask
    task automatic t_pfail();
        wr_reg(C, 8'h08);
        @(posedge clk) pf_n <= 0;
        idle(3);
        chk("pfail irq", 8'(err_irq), 8'h01);
        @(posedge clk) pf_n <= 1;
        rd_reg(A2, 8'h20, "pfail set");
        wr_reg(A2, 8'h02);
        rd_reg(A2, 8'h00, "pfail write clear");
        @(posedge clk) pf_n <= 0;
        @(posedge clk) pf_n <= 1;
        wr_reg(C, 8'h00);
        rd_reg(A2, 8'h00, "pfail disable clear");
        @(posedge clk) pf_n <= 0;
        idle(3);
        chk("pfail ignored", 8'(err_irq), 8'h00);
        @(posedge clk) pf_n <= 1;
        bat <= 0;
        idle(3);
        chk("battery low", 8'(err_irq), 8'h01);
        @(posedge clk) bat <= 1;
        wr_reg(A2, 8'h02);
        rd_reg(A2, 8'h00, "battery clear");
        @(posedge clk) pgood <= 0;
        idle(3);
        chk("power good low", 8'(err_irq), 8'h01);
        @(posedge clk) pgood <= 1;
        wr_reg(A2, 8'h02);
        rd_reg(A2, 8'h00, "power good clear");
        $display("power fail test done");
    endtask
    task automatic t_ring();
        wr_reg(C, 8'h10);
        @(posedge clk) ring <= 0;
        idle(3);
        chk("ring falling", 8'(ring_irq), 8'h01);
        rd_reg(M, 8'h01, "modem pending");
        wr_reg(M, 8'h02);
        idle(2);
        chk("ring cleared", 8'(ring_irq), 8'h00);
        @(posedge clk) ring <= 1;
        idle(3);
        chk("ring rising", 8'(ring_irq), 8'h01);
        wr_reg(M, 8'h00);
        wr_reg(C, 8'h00);
        @(posedge clk) ring <= 0;
        idle(3);
        chk("ring disabled", 8'(ring_irq), 8'h00);
        wr_reg(C, 8'h12);
        idle(2);
        chk("ring level 15", {6'h00, err_irq, ring_irq}, 8'h02);
        @(posedge clk) ring <= 1;
        wr_reg(M, 8'h00);
        $display("ring test done");
    endtask
    task automatic t_misc();
        @(posedge clk) mot2 <= 1;
        alt_in <= 1;
        wr_reg(C, 8'h05);
        idle(2);
        chk("density alt on", {6'h00, dens, alt_irq}, 8'h03);
        wr_reg(C, 8'h00);
        idle(2);
        chk("density alt off", {6'h00, dens, alt_irq}, 8'h00);
        @(posedge clk) dflt <= 1;
        idle(2);
        chk("density default", {7'h00, dens}, 8'h01);
        @(posedge clk) dflt <= 0;
        $display("density and mode test done");
    endtask
    task automatic t_diag();
        wr_reg(C, 8'h1F);
        wr_reg(A2, 8'hDD);
        wr_reg(M, 8'h02);
        wr_reg(D, 8'hA5);
        @(posedge clk) rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd_reg(D, 8'hA5, "diag kept");
        rd_reg(C, 8'h00, "config reset");
        rd_reg(A1, 8'h20, "aux1 reset");
        rd_reg(A2, 8'h00, "aux2 reset");
        rd_reg(M, 8'h04, "modem reset");
        rd_reg(36'h000000004, 8'h00, "unmapped");
        $display("reset test done");
    endtask
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        t_aux1();
        t_aux2();
        t_pfail();
        t_ring();
        t_misc();
        t_diag();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule
